// *** rtl/dac_host_pin_control.sv ***
// pin-level digital control of a quad output converter: serial link,
// address decode, output loading, clear, watchdog alert, fault, strap
// assumes sclk runs only while sync_n is low; the host keeps serial_data_in and
// sync_n set up to the falling edge of sclk
//
// Overview of operation
// (RQ1) shift serial_data_in on sclk fall, frame low
// (RQ2) host keeps sclk at or below 30 MHz
// (RQ3) readback mode shifts the serial word out
// (RQ4) board address from the two strap pins
// (RQ5) load low: output updates at frame end
// (RQ6) load high: input only, output on fall
// (RQ7) clear edge presets enabled channels only
// (RQ8) clear held: output registers refuse writes
// (RQ9) alert after interface silent for timeout
// (RQ10) fault pulls low on any fault source
// (RQ11) strap sampled after power-up and reset
// (RQ12) strap 0: voltage and current tristated
// (RQ13) strap 1: voltage pulled down, current tristated
// (RQ14) active-low reset restores state, resamples strap
// (RQ15) readback bits launched on sclk rise
// (RQ16) frames for another board address ignored
`default_nettype none

module dac_host_pin_control #(
   parameter int WDOG_CYCLES = dac_pin_pkg::WDOG_CYCLES
) (
   input  wire logic         clock,
   input  wire logic         rst_n,
   input  wire logic         sclk,
   input  wire logic         sync_n,
   input  wire logic         serial_data_in,
   output logic              serial_data_out,
   input  wire logic         load_outputs_n,
   input  wire logic         clear,
   input  wire logic         board_addr_bit0,
   input  wire logic         board_addr_bit1,
   input  wire logic         power_on_state_strap,
   input  wire logic [3:0]   clear_enable,
   input  wire logic [63:0]  clear_codes,
   input  wire logic [3:0]   open_circuit,
   input  wire logic [3:0]   short_circuit,
   input  wire logic         pec_error,
   input  wire logic         over_temp,
   output logic              alert,
   output logic              fault_n_o,
   output logic              fault_n_oe,
   output logic [63:0]       dac_codes,
   output logic [3:0]        current_mode,
   output logic [3:0]        vout_hiz,
   output logic [3:0]        iout_hiz,
   output logic [3:0]        vout_pulldown
);

   localparam int PIN_W = 21;

   // picks bit n of a frame word, msb first; out of range reads zero
   function automatic logic frame_bit(input logic [23:0] word,
                                      input logic [4:0]  n);
      logic [4:0] idx;
      idx = 5'(dac_pin_pkg::FRAME_BITS - 1) - n;
      frame_bit = (n < 5'(dac_pin_pkg::FRAME_BITS)) ? word[idx] : 1'b0;
   endfunction : frame_bit

   // selects one channel's code from a packed group of four
   function automatic logic [15:0] code_of(input logic [63:0] codes,
                                           input logic [1:0]  ch);
      code_of = codes[ch*dac_pin_pkg::CODE_W +: dac_pin_pkg::CODE_W];
   endfunction : code_of

   // ---------------- link domain (sclk) ----------------
   logic        armed_reg;
   logic [4:0]  count_reg;
   logic [4:0]  count_next;
   logic [23:0] shift_reg;
   logic        sdo_reg;
   logic        sdo_next;
   logic [4:0]  out_index;
   logic        frame_ok_reg;
   logic        rb_active_reg;
   logic [23:0] rb_word_reg;

   // armed marks a frame with no clock edge yet; set by sync_n itself
   // because sclk stands still between frames
   always_ff @(negedge sclk or posedge sync_n) begin
      if (sync_n) begin
         armed_reg <= 1'b1;
      end else begin
         armed_reg <= 1'b0;
      end
   end

   assign count_next = armed_reg ? 5'h01 :
                       (count_reg == dac_pin_pkg::COUNT_MAX) ? count_reg :
                       count_reg + 5'h01;

   // no reset here: the count restarts at each frame's first edge
   always_ff @(negedge sclk) begin
      if (!sync_n) begin
         shift_reg <= {shift_reg[22:0], serial_data_in}; // RQ1
         count_reg <= count_next;
      end
   end

   // length verdict taken as the frame closes: armed is preset by this
   // same edge, so the system side could never see it cleared afterwards
   always_ff @(posedge sync_n) begin
      frame_ok_reg <= ~armed_reg & (count_reg == dac_pin_pkg::COUNT_FRAME);
   end

   assign out_index = armed_reg ? dac_pin_pkg::COUNT_RESET : count_reg;
   assign sdo_next  = rb_active_reg & frame_bit(rb_word_reg, out_index); // RQ3

   always_ff @(posedge sclk or posedge sync_n) begin
      if (sync_n) begin
         sdo_reg <= 1'b0;
      end else begin
         sdo_reg <= sdo_next; // RQ15
      end
   end

   assign serial_data_out = sdo_reg;

   // ---------------- system domain ----------------
   logic [PIN_W-1:0] pins_raw;
   logic [PIN_W-1:0] pins_s;
   logic [63:0]      clear_codes_s;

   assign pins_raw = {sync_n, serial_data_in, load_outputs_n, clear,
                      board_addr_bit1, board_addr_bit0, power_on_state_strap,
                      clear_enable, open_circuit, short_circuit,
                      pec_error, over_temp};

   pin_sync #(
      .WIDTH     (PIN_W),
      .RESET_VAL ({3'b111, 18'h00000})
   ) u_pin_sync (
      .clock     (clock),
      .rst_n     (rst_n),
      .pin_in    (pins_raw),
      .level_out (pins_s)
   );

   // clear codes are configuration: stable long before any clear edge
   pin_sync #(
      .WIDTH     (64),
      .RESET_VAL (64'h0)
   ) u_code_sync (
      .clock     (clock),
      .rst_n     (rst_n),
      .pin_in    (clear_codes),
      .level_out (clear_codes_s)
   );

   wire       sync_s     = pins_s[20];
   wire       serial_data_in_s     = pins_s[19];
   wire       load_outputs_n_s     = pins_s[18];
   wire       clear_s    = pins_s[17];
   wire [1:0] addr_s     = pins_s[16:15];
   wire       strap_s    = pins_s[14];
   wire [3:0] clr_en_s   = pins_s[13:10];
   wire [3:0] open_s     = pins_s[9:6];
   wire [3:0] short_s    = pins_s[5:2];
   wire       pec_s      = pins_s[1];
   wire       temp_s     = pins_s[0];

   dac_pin_pkg::state_t state_reg;
   dac_pin_pkg::state_t state_next;
   logic        strap_reg;
   logic        sync_prev_reg;
   logic        serial_data_in_prev_reg;
   logic        load_outputs_n_prev_reg;
   logic        clear_prev_reg;
   logic [31:0] wdog_reg;
   logic [31:0] wdog_next;
   logic        alert_reg;
   logic        alert_next;
   logic        fault_reg;
   logic        rb_active_next;
   logic [23:0] rb_word_next;
   logic [63:0] in_codes_reg;
   logic [63:0] in_codes_next;
   logic [63:0] out_codes_reg;
   logic [63:0] out_codes_next;
   logic [3:0]  pending_reg;
   logic [3:0]  pending_next;
   logic [3:0]  mode_reg;
   logic [3:0]  mode_next;
   logic [3:0]  released_reg;
   logic [3:0]  released_next;
   logic [3:0]  vhiz_reg;
   logic [3:0]  ihiz_reg;
   logic [3:0]  vpd_reg;

   // power-on sequencing
   always_comb begin
      case (state_reg)
         dac_pin_pkg::ST_SETTLE1: state_next = dac_pin_pkg::ST_SETTLE2;
         dac_pin_pkg::ST_SETTLE2: state_next = dac_pin_pkg::ST_SAMPLE;
         dac_pin_pkg::ST_SAMPLE:  state_next = dac_pin_pkg::ST_RUN;
         dac_pin_pkg::ST_RUN:     state_next = dac_pin_pkg::ST_RUN;
         default:                 state_next = dac_pin_pkg::ST_SETTLE1;
      endcase
   end

   wire running = (state_reg == dac_pin_pkg::ST_RUN);

   // event detection on synchronised levels
   wire frame_end  = running & sync_s & ~sync_prev_reg;
   wire activity   = (sync_s ^ sync_prev_reg) | (serial_data_in_s ^ serial_data_in_prev_reg);
   wire load_outputs_n_fall  = running & load_outputs_n_prev_reg & ~load_outputs_n_s;
   wire load_outputs_n_low   = ~load_outputs_n_s;
   wire clear_rise = running & clear_s & ~clear_prev_reg;

   // link-domain word is static once sync_n is high and sclk has stopped
   wire len_ok     = frame_ok_reg;
   wire addr_match = shift_reg[dac_pin_pkg::ADDR_HI:dac_pin_pkg::ADDR_LO]
                     == addr_s; // RQ4
   wire frame_hit  = frame_end & len_ok & addr_match; // RQ16
   wire is_read    = shift_reg[dac_pin_pkg::READ_BIT];
   wire wr_hit     = frame_hit & ~is_read;
   wire rd_hit     = frame_hit & is_read;
   wire [1:0]  ch  = shift_reg[dac_pin_pkg::CH_HI:dac_pin_pkg::CH_LO];
   wire [15:0] wr_data = shift_reg[dac_pin_pkg::DATA_HI:dac_pin_pkg::DATA_LO];
   wire wr_mode    = shift_reg[dac_pin_pkg::MODE_BIT];

   // per-channel loading, clear and output state
   genvar c;
   generate
      for (c = 0; c < dac_pin_pkg::NUM_CH; c++) begin : g_ch
         localparam int LO = c * dac_pin_pkg::CODE_W;
         wire        wr_c     = wr_hit & (ch == 2'(c));
         wire        direct_c = wr_c & load_outputs_n_low; // RQ5
         wire        defer_c  = load_outputs_n_fall & pending_reg[c]; // RQ6
         wire        load_c   = (direct_c | defer_c) & ~clear_s; // RQ8
         wire        clr_c    = clear_rise & clr_en_s[c]; // RQ7
         wire [15:0] src_c    = direct_c ? wr_data
                                : in_codes_reg[LO +: dac_pin_pkg::CODE_W];
         wire [15:0] cur_c    = out_codes_reg[LO +: dac_pin_pkg::CODE_W];

         assign in_codes_next[LO +: dac_pin_pkg::CODE_W] =
            wr_c ? wr_data : in_codes_reg[LO +: dac_pin_pkg::CODE_W];
         assign out_codes_next[LO +: dac_pin_pkg::CODE_W] =
            clr_c  ? code_of(clear_codes_s, 2'(c)) :
            load_c ? src_c : cur_c;
         // a write arriving with the load edge goes straight to the output, not pending
         assign pending_next[c]  = (wr_c & ~load_outputs_n_low) |
                                   (pending_reg[c] & ~load_outputs_n_fall); // RQ6
         assign mode_next[c]     = wr_c ? wr_mode : mode_reg[c];
         assign released_next[c] = released_reg[c] | load_c | clr_c;
      end
   endgenerate

   // readback holds the addressed channel's output code for the next frame
   assign rb_word_next   = rd_hit ? {shift_reg[23:16], code_of(out_codes_reg, ch)}
                                  : rb_word_reg;
   assign rb_active_next = frame_end ? rd_hit : rb_active_reg; // RQ3

   // watchdog on interface pin activity
   assign wdog_next  = (activity | ~running) ? 32'h0 :
                       alert_reg ? wdog_reg : wdog_reg + 32'h1;
   assign alert_next = running & ~activity &
                       (alert_reg | (wdog_reg == 32'(WDOG_CYCLES - 1))); // RQ9

   wire fault_any = (|open_s) | (|short_s) | pec_s | temp_s; // RQ10

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         state_reg <= dac_pin_pkg::ST_SETTLE1; // RQ14
      end else begin
         state_reg <= state_next;
      end
   end

   // strap is caught only once the synchroniser holds the pin level
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         strap_reg <= 1'b0;
      end else if (state_reg == dac_pin_pkg::ST_SAMPLE) begin
         strap_reg <= strap_s; // RQ11
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         sync_prev_reg  <= 1'b1;
         serial_data_in_prev_reg  <= 1'b0;
         load_outputs_n_prev_reg  <= 1'b1;
         clear_prev_reg <= 1'b0;
      end else begin
         sync_prev_reg  <= sync_s;
         serial_data_in_prev_reg  <= serial_data_in_s;
         load_outputs_n_prev_reg  <= load_outputs_n_s;
         clear_prev_reg <= clear_s;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         in_codes_reg  <= {4{dac_pin_pkg::CODE_RESET}};
         out_codes_reg <= {4{dac_pin_pkg::CODE_RESET}};
         pending_reg   <= 4'h0;
         mode_reg      <= 4'h0;
         released_reg  <= 4'h0;
      end else begin
         in_codes_reg  <= in_codes_next;
         out_codes_reg <= out_codes_next;
         pending_reg   <= pending_next;
         mode_reg      <= mode_next;
         released_reg  <= released_next;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         rb_word_reg   <= 24'h000000;
         rb_active_reg <= 1'b0;
         wdog_reg      <= 32'h0;
         alert_reg     <= 1'b0;
         fault_reg     <= 1'b0;
      end else begin
         rb_word_reg   <= rb_word_next;
         rb_active_reg <= rb_active_next;
         wdog_reg      <= wdog_next;
         alert_reg     <= alert_next;
         fault_reg     <= fault_any; // RQ10
      end
   end

   // output stage: power-on state holds until a channel is first loaded or preset by clear
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         vhiz_reg <= 4'hf;
         ihiz_reg <= 4'hf;
         vpd_reg  <= 4'h0;
      end else begin
         vhiz_reg <= ~released_next | mode_next; // RQ12
         ihiz_reg <= ~released_next | ~mode_next; // RQ12
         vpd_reg  <= ~released_next & {4{strap_reg}}; // RQ13
      end
   end

   assign alert         = alert_reg;
   assign fault_n_o     = ~fault_reg;
   assign fault_n_oe    = fault_reg;
   assign dac_codes     = out_codes_reg;
   assign current_mode  = mode_reg;
   assign vout_hiz      = vhiz_reg;
   assign iout_hiz      = ihiz_reg;
   assign vout_pulldown = vpd_reg;

endmodule : dac_host_pin_control

`default_nettype wire

// *** rtl/dac_pin_pkg.sv ***
// constants, field layout and state type for the converter pin control
// assumes a 10 MHz system clock and a 24-bit serial frame, msb first
`default_nettype none

package dac_pin_pkg;

   // system clock rate and watchdog time
   localparam int CLOCK_MHZ       = 10;
   localparam int WDOG_TIMEOUT_US = 5000;
   localparam int WDOG_CYCLES     = WDOG_TIMEOUT_US * CLOCK_MHZ;

   // serial frame layout
   localparam int FRAME_BITS = 24;
   localparam int ADDR_HI    = 23;
   localparam int ADDR_LO    = 22;
   localparam int READ_BIT   = 21;
   localparam int MODE_BIT   = 20;
   localparam int CH_HI      = 17;
   localparam int CH_LO      = 16;
   localparam int DATA_HI    = 15;
   localparam int DATA_LO    = 0;

   // channel geometry
   localparam int NUM_CH = 4;
   localparam int CODE_W = 16;

   // reset values and bit count limits
   localparam logic [15:0] CODE_RESET   = 16'h0000;
   localparam logic [4:0]  COUNT_RESET  = 5'h00;
   localparam logic [4:0]  COUNT_MAX    = 5'h1f;
   localparam logic [4:0]  COUNT_FRAME  = 5'h18;

   // power-on sequencing: let the strap pass its synchroniser first
   typedef enum logic [1:0] {
      ST_SETTLE1,
      ST_SETTLE2,
      ST_SAMPLE,
      ST_RUN
   } state_t;

endpackage : dac_pin_pkg

`default_nettype wire

// *** rtl/pin_sync.sv ***
// two flip-flop synchroniser for a group of slow pin levels
// assumes each bit is a level; multi-bit groups must be quasi-static
`default_nettype none

module pin_sync #(
   parameter int                 WIDTH     = 1,
   parameter logic [WIDTH-1:0]   RESET_VAL = '0
) (
   input  wire logic              clock,
   input  wire logic              rst_n,
   input  wire logic [WIDTH-1:0]  pin_in,
   output logic      [WIDTH-1:0]  level_out
);

   logic [WIDTH-1:0] meta_reg;
   logic [WIDTH-1:0] level_reg;

   // first stage feeds only the second stage
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         meta_reg  <= RESET_VAL;
         level_reg <= RESET_VAL;
      end else begin
         meta_reg  <= pin_in;
         level_reg <= meta_reg;
      end
   end

   assign level_out = level_reg;

endmodule : pin_sync

`default_nettype wire

// *** test/dac_pin_monitor.sv ***
// checker for the converter pin control: alert, fault, clear, load, strap
// assumes it is bound to dac_host_pin_control and clear_codes is static
`default_nettype none

module dac_pin_monitor #(
   parameter int WDOG_CYCLES = 64
) (
   input wire logic        clock,
   input wire logic        rst_n,
   input wire logic        sync_n,
   input wire logic        serial_data_in,
   input wire logic        serial_data_out,
   input wire logic        load_outputs_n,
   input wire logic        clear,
   input wire logic        power_on_state_strap,
   input wire logic [3:0]  clear_enable,
   input wire logic [63:0] clear_codes,
   input wire logic [3:0]  open_circuit,
   input wire logic [3:0]  short_circuit,
   input wire logic        pec_error,
   input wire logic        over_temp,
   input wire logic        alert,
   input wire logic        fault_n_o,
   input wire logic        fault_n_oe,
   input wire logic [63:0] dac_codes,
   input wire logic [3:0]  iout_hiz,
   input wire logic [3:0]  vout_pulldown
);
   timeunit 1ns;
   timeprecision 100ps;

   logic [15:0]      quiet_reg;
   logic [7:0]       age_reg;
   wire logic        fault_src = |{open_circuit, short_circuit, pec_error, over_temp};
   wire logic [63:0] clr_mask  = {{16{clear_enable[3]}}, {16{clear_enable[2]}},
                                  {16{clear_enable[1]}}, {16{clear_enable[0]}}};

   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   // raw pin view: the design's syncs only lag this count, never lead it
   always_ff @(posedge clock) begin
      if (!rst_n || $changed(sync_n) || $changed(serial_data_in)) quiet_reg <= 16'h0000;
      else if (quiet_reg != 16'hffff) quiet_reg <= quiet_reg + 16'h0001;
   end

   // cycles since anything that may move an output code
   always_ff @(posedge clock) begin
      if (!rst_n || $rose(sync_n) || $fell(load_outputs_n) || $rose(clear)) age_reg <= 8'h00;
      else if (age_reg != 8'hff) age_reg <= age_reg + 8'h01;
   end

   a_fault_follows_src: assert property ($stable(fault_src) [*4] |-> fault_n_oe == fault_src)
      else $error("fault drive does not follow fault sources");
   a_fault_pin_pair: assert property (fault_n_o == !fault_n_oe)
      else $error("fault level and enable disagree");
   a_alert_late: assert property (quiet_reg == WDOG_CYCLES + 10 |-> alert)
      else $error("alert missing after quiet link");
   a_alert_early: assert property ($rose(alert) |-> quiet_reg >= WDOG_CYCLES)
      else $error("alert raised too early");
   a_clear_preset: assert property ($rose(clear) |-> ##[1:4] ((dac_codes ^ clear_codes) & clr_mask) == 64'h0)
      else $error("enabled channels not preset by clear");
   a_clear_others: assert property ($rose(clear) && age_reg > 8'h06 |-> ##1 $stable(dac_codes & ~clr_mask) [*5])
      else $error("clear moved a disabled channel");
   a_clear_blocks: assert property (clear [*8] |-> $stable(dac_codes))
      else $error("output code written while clear held");
   a_load_defers: assert property ((load_outputs_n && !clear) [*8] |-> $stable(dac_codes))
      else $error("output code moved while load line high");
   a_codes_need_cause: assert property ($changed(dac_codes) |-> age_reg <= 8'h06)
      else $error("output code moved without a cause");
   a_readout_idle: assert property (sync_n && $past(sync_n) |-> serial_data_out == 1'b0)
      else $error("readback line busy outside a frame");
   a_strap_state: assert property ($rose(rst_n) |-> ##6 vout_pulldown == {4{power_on_state_strap}} && iout_hiz == 4'hf)
      else $error("power-on output state wrong");

   c_alert: cover property ($rose(alert));
   c_clear: cover property ($rose(clear) ##4 clear);
   c_load: cover property ($fell(load_outputs_n));
endmodule : dac_pin_monitor

bind dac_host_pin_control dac_pin_monitor #(.WDOG_CYCLES(WDOG_CYCLES)) i_monitor (.*);

`default_nettype wire

// *** test/host_link_model.sv ***
// serial host model: frames words onto the link, gathers readback bits
// assumes sclk idles low and stands still between frames
`default_nettype none

module host_link_model (
   output logic     sclk,
   output logic     sync_n,
   output logic     serial_data_in,
   input wire logic serial_data_out
);
   timeunit 1ns;
   timeprecision 100ps;

   initial begin
      sclk           = 1'b0;
      sync_n         = 1'b1;
      serial_data_in = 1'b0;
   end

   // one 24-bit frame msb first at a 34 ns link period, then the 5 us gap;
   // data moves inside the low phase, clear of both clock edges
   task automatic frame(input logic [23:0] word, output logic [23:0] rdata);
      #3 sync_n = 1'b0;
      for (int i = 23; i >= 0; i--) begin
         #6 serial_data_in = word[i];
         #11 sclk = 1'b1;
         #17 sclk = 1'b0;
         rdata[i] = serial_data_out;
      end
      // released line shows the inverse, not a stale level
      #6 serial_data_in = ~serial_data_in;
      #6 sync_n = 1'b1;
      #5000;
   endtask : frame
endmodule : host_link_model

`default_nettype wire

// *** test/testbench.sv ***
// self-checking bench for the converter pin control
// assumes the host model on the link and the checker bound to the design
`default_nettype none

module testbench;
   timeunit 1ns;
   timeprecision 100ps;

   localparam int         WDOG  = 64;
   localparam logic [1:0] BOARD = 2'b10;

   logic        clock, rst_n, sclk, sync_n, serial_data_in, serial_data_out;
   logic        load_outputs_n, clear, board_addr_bit0, board_addr_bit1;
   logic        power_on_state_strap, pec_error, over_temp, alert, fault_n_o, fault_n_oe;
   logic [3:0]  clear_enable, open_circuit, short_circuit, current_mode;
   logic [3:0]  vout_hiz, iout_hiz, vout_pulldown;
   logic [63:0] clear_codes, dac_codes;
   logic [9:0]  faults;
   logic [23:0] rdata;
   logic [1:0]  board;
   int          fail_count = 0;
   int          comparisons = 0;

   assign {open_circuit, short_circuit, pec_error, over_temp} = faults;
   assign {board_addr_bit1, board_addr_bit0} = board;

   dac_host_pin_control #(.WDOG_CYCLES(WDOG)) i_dut (.*);
   host_link_model i_host (.*);

   initial begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end

   task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fail_count++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic cyc(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask : cyc

   function automatic logic [23:0] mk(logic [1:0] a, logic rd, logic md, logic [1:0] ch,
                                      logic [15:0] code);
      return {a, rd, md, 2'b00, ch, code};
   endfunction : mk

   task automatic send(input logic [23:0] w);
      @(posedge clock);
      i_host.frame(w, rdata);
   endtask : send

   task automatic do_reset(input logic strap);
      @(posedge clock);
      rst_n                <= 1'b0;
      power_on_state_strap <= strap;
      repeat (20) @(posedge clock);
      rst_n <= 1'b1;
      cyc(8);
   endtask : do_reset

   task automatic t_power_state;
      check("pulldown", vout_pulldown, 4'hf);
      check("iout_hiz", iout_hiz, 4'hf);
      do_reset(1'b0);
      check("pulldown", vout_pulldown, 4'h0);
      check("hiz", {vout_hiz, iout_hiz}, 8'hff);
      $display("power state done");
   endtask : t_power_state

   task automatic t_write;
      send(mk(BOARD, 1'b0, 1'b1, 2'h1, 16'h1234));
      check("code1", dac_codes[31:16], 16'h1234);
      check("mode1", current_mode[1], 1'b1);
      check("stage1", {vout_hiz[1], iout_hiz[1], vout_pulldown[1]}, 3'b100);
      send(mk(~BOARD, 1'b0, 1'b0, 2'h1, 16'habcd));
      check("code1 other board", dac_codes[31:16], 16'h1234);
      @(posedge clock) board <= ~BOARD;
      cyc(3);
      send(mk(~BOARD, 1'b0, 1'b0, 2'h3, 16'h0bad));
      check("code3 new straps", dac_codes[63:48], 16'h0bad);
      @(posedge clock) board <= BOARD;
      cyc(3);
      send(mk(BOARD, 1'b1, 1'b0, 2'h1, 16'h0000));
      send(mk(BOARD, 1'b1, 1'b0, 2'h3, 16'h0000));
      check("readback", rdata, 24'ha11234);
      $display("write and readback done");
   endtask : t_write

   task automatic t_deferred;
      @(posedge clock) load_outputs_n <= 1'b1;
      send(mk(BOARD, 1'b0, 1'b0, 2'h0, 16'h5555));
      send(mk(BOARD, 1'b0, 1'b0, 2'h2, 16'haaaa));
      check("held", {dac_codes[47:32], dac_codes[15:0]}, 32'h0);
      @(posedge clock) load_outputs_n <= 1'b0;
      cyc(5);
      check("loaded", {dac_codes[47:32], dac_codes[15:0]}, 32'haaaa5555);
      $display("deferred load done");
   endtask : t_deferred

   task automatic t_clear;
      @(posedge clock) clear_enable <= 4'h5;
      cyc(4);
      @(posedge clock) clear <= 1'b1;
      cyc(5);
      check("cleared", dac_codes, {16'h0bad, 16'h3333, 16'h1234, 16'h1111});
      send(mk(BOARD, 1'b0, 1'b0, 2'h0, 16'h7777));
      check("blocked", dac_codes[15:0], 16'h1111);
      @(posedge clock) clear <= 1'b0;
      $display("clear done");
   endtask : t_clear

   task automatic t_fault;
      for (int k = 0; k < 10; k++) begin
         @(posedge clock) faults <= 10'h001 << k;
         cyc(5);
         check("fault", {fault_n_oe, fault_n_o}, 2'b10);
      end
      @(posedge clock) faults <= 10'h000;
      cyc(5);
      check("fault idle", {fault_n_oe, fault_n_o}, 2'b01);
      $display("fault done");
   endtask : t_fault

   task automatic t_alert;
      cyc(WDOG + 12);
      check("alert", alert, 1'b1);
      send(mk(~BOARD, 1'b0, 1'b0, 2'h0, 16'h0000));
      check("alert cleared", alert, 1'b0);
      $display("alert done");
   endtask : t_alert

   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : tally_and_finish

   initial begin
      {rst_n, load_outputs_n, clear, power_on_state_strap} = 4'b0001;
      {clear_enable, faults} = 14'h0000;
      clear_codes = 64'h4444_3333_2222_1111;
      board       = BOARD;
      do_reset(1'b1);
      t_power_state();
      t_write();
      t_deferred();
      t_clear();
      t_fault();
      t_alert();
      tally_and_finish();
   end

   // run needs about 760 cycles
   initial begin
      repeat (5000) @(posedge clock);
      fail_count++;
      tally_and_finish();
   end
endmodule : testbench

`default_nettype wire
